// >>> scp_host_model.sv
// serial host model: streams command strings into the parser
// assumes one shared core_clk; bytes change only after a rising edge
`timescale 1ns/100ps
`default_nettype none
module scp_host_model (
  // clock
  input  wire logic       core_clk,
  // serial receive bytes
  output var  logic       rxValid,
  output var  logic [7:0] rxData
);
  initial
  begin
    rxValid = 1'b0;
    rxData  = 8'h00;
  end
  // gap idle cycles between bytes model a slow sender
  task automatic sendStr(input string s, input int gap);
    for (int i = 0; i < s.len(); i++)
    begin
      @(posedge core_clk);
      rxValid <= 1'b1;
      rxData  <= s[i];
      repeat (gap)
      begin
        @(posedge core_clk);
        rxValid <= 1'b0;
        rxData  <= ~s[i];
      end
    end
    // an idle line shows the inverse of the last byte
    @(posedge core_clk);
    rxValid <= 1'b0;
    rxData  <= ~s[s.len()-1];
  endtask
endmodule
`default_nettype wire

// >>> scp_parser.sv
// connect command parser, autostart and ordered host table scroller
// assumes serial bytes and connection engine events arrive on core_clk
`timescale 1ns/100ps
`default_nettype none

// How it works
// RQ1: manual mode connects only on a command
// RQ2: command must start with letter C
// RQ3: CR or LF ends the command
// RQ4: host sends no spaces in command
// RQ5: dotted decimal address, one to four bytes
// RQ6: host puts periods between address numbers
// RQ7: optional slash then decimal port 1-65535
// RQ8: no port given uses stored port
// RQ9: partial address fills high bytes from stored
// RQ10: 0.0.0.0/0 enters monitor state instead
// RQ11: non-digit after C means host name
// RQ12: name port follows slash or colon
// RQ13: autostart connects to stored target at boot
// RQ14: table tried in turn until connected
// RQ15: lost table connection resumes scrolling
// RQ16: table holds one to twelve entries
// RQ17: table unused in manual or modem mode
// RQ18: table mode refuses incoming connections
// RQ19: per-entry retry count 1-15, default 3
// RQ20: attempt timeout 10-65535 ms, default 250
// RQ21: malformed command discarded, no connection
// RQ22: after last entry wrap to first
module scp_parser #(
  parameter int CYC_PER_MS = scp_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // register bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // serial receive bytes
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  // connection engine
  output scp_pkg::scp_req_s connCmd,
  output logic             nameValid,
  output logic      [7:0]  nameData,
  output logic             connCancel,
  output logic             monitorEnter,
  output logic             refuseIncoming,
  input  wire logic        connUp,
  input  wire logic        connFail,
  input  wire logic        connDown
);
  scp_pkg::scp_cfg_s cfg, next_cfg;
  scp_pkg::scp_prs_s prs, next_prs;
  scp_pkg::scp_hl_s  hl, next_hl;
  scp_pkg::scp_req_s next_connCmd;
  logic              ack, next_ack;
  logic [31:0]       rdat, next_rdat;
  logic              next_nameValid, next_monitorEnter, next_connCancel;
  logic [7:0]        next_nameData;
  logic              bootPend, next_bootPend;
  logic              modemOn, manualOn, listOn, autoOn;
  logic [3:0]        hlCount;
  logic              isTerm, isDigit;
  logic [7:0]        digit;

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  assign modemOn  = cfg.policy[7:6] == 2'b11 && cfg.policy[2:1] == 2'b11;
  assign listOn   = cfg.policy[7:4] == scp_pkg::POL_LIST
                    && cfg.policy[3:0] != scp_pkg::POL_MANUAL && !modemOn; // see RQ17
  assign manualOn = cfg.policy[3:0] == scp_pkg::POL_MANUAL && !modemOn;
  assign autoOn   = cfg.policy[3:0] == scp_pkg::POL_AUTO && !listOn && !modemOn;
  assign refuseIncoming = listOn; // see RQ18
  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;
  assign isTerm   = rxData == scp_pkg::CH_CR || rxData == scp_pkg::CH_LF; // see RQ3
  assign isDigit  = rxData >= scp_pkg::CH_ZERO && rxData <= scp_pkg::CH_NINE;
  assign digit    = rxData - scp_pkg::CH_ZERO;

  // leading nonzero table entries count as the live list
  always_comb
  begin
    logic stop;
    stop = 1'b0;
    hlCount = 4'h0;
    for (int i = 0; i < scp_pkg::HOST_MAX; i++)
      if (!stop && cfg.hAddr[i] != 32'h0000_0000)
        hlCount = hlCount + 4'h1; // see RQ16
      else
        stop = 1'b1;
  end

  // register bus: one wait state, write lands on the ack edge
  always_comb
  begin
    logic [7:0] off;
    logic [3:0] hIdx;
    logic       hHit;
    logic [31:0] rd;
    logic [31:0] lm;
    off  = wb_adr_i - scp_pkg::REG_HOST;
    hIdx = off[6:3];
    hHit = wb_adr_i >= scp_pkg::REG_HOST && !off[7] && int'(hIdx) < scp_pkg::HOST_MAX;
    lm   = 32'h0000_0000;
    next_cfg = cfg;
    next_ack = wb_cyc_i && wb_stb_i && !ack;
    next_rdat = rdat;
    rd = 32'h0000_0000;
    unique case ({wb_adr_i[7:2], 2'b00})
      scp_pkg::REG_POLICY:   rd = {24'h00_0000, cfg.policy};
      scp_pkg::REG_REM_ADDR: rd = cfg.remAddr;
      scp_pkg::REG_REM_PORT: rd = {16'h0000, cfg.remPort};
      scp_pkg::REG_RETRY:    rd = {28'h000_0000, cfg.retry};
      scp_pkg::REG_TMO:      rd = {16'h0000, cfg.tmo};
      scp_pkg::REG_STATUS:   rd = {12'h000, 3'(prs.st), listOn, manualOn, autoOn,
                                   2'(hl.st), hl.idx, hl.tries, hlCount};
      default:
        if (hHit)
          rd = off[2] ? {16'h0000, cfg.hPort[hIdx]} : cfg.hAddr[hIdx];
    endcase
    if (next_ack)
      next_rdat = rd;
    if (wb_cyc_i && wb_stb_i && wb_we_i && ack)
    begin
      unique case ({wb_adr_i[7:2], 2'b00})
        scp_pkg::REG_POLICY:
        begin
          lm = laneMerge({24'h00_0000, cfg.policy}, wb_dat_i, wb_sel_i);
          next_cfg.policy = lm[7:0];
        end
        scp_pkg::REG_REM_ADDR:
          next_cfg.remAddr = laneMerge(cfg.remAddr, wb_dat_i, wb_sel_i);
        scp_pkg::REG_REM_PORT:
        begin
          lm = laneMerge({16'h0000, cfg.remPort}, wb_dat_i, wb_sel_i);
          next_cfg.remPort = lm[15:0];
        end
        scp_pkg::REG_RETRY:
          if (wb_sel_i[0])
            next_cfg.retry = wb_dat_i[3:0] < scp_pkg::RETRY_MIN ? scp_pkg::RETRY_MIN
                                                               : wb_dat_i[3:0]; // see RQ19
        scp_pkg::REG_TMO:
        begin
          lm = laneMerge({16'h0000, cfg.tmo}, wb_dat_i, wb_sel_i);
          next_cfg.tmo = lm[15:0];
          if (next_cfg.tmo < scp_pkg::TMO_MIN)
            next_cfg.tmo = scp_pkg::TMO_MIN; // see RQ20
        end
        default:
          if (hHit && off[2])
          begin
            lm = laneMerge({16'h0000, cfg.hPort[hIdx]}, wb_dat_i, wb_sel_i);
            next_cfg.hPort[hIdx] = lm[15:0];
          end
          else if (hHit)
            next_cfg.hAddr[hIdx] = laneMerge(cfg.hAddr[hIdx], wb_dat_i, wb_sel_i);
      endcase
    end
  end

  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      cfg  <= scp_pkg::CFG_RST;
      ack  <= 1'b0;
      rdat <= 32'h0000_0000;
    end
    else
    begin
      cfg  <= next_cfg;
      ack  <= next_ack;
      rdat <= next_rdat;
    end

  // command parser, autostart and host table
  always_comb
  begin
    logic [11:0] ow;
    logic [19:0] pw;
    logic [31:0] fa;
    logic [2:0]  fn;
    logic        fin, nameFin;
    logic [3:0]  nextIdx;
    ow = 12'(prs.acc) * 12'd10 + 12'(digit);
    pw = 20'(prs.port) * 20'd10 + 20'(digit);
    fa = {prs.addr[23:0], prs.acc};
    fn = prs.nOct + 3'd1;
    fin = 1'b0;
    nameFin = 1'b0;
    nextIdx = (hl.idx + 4'h1 >= hlCount) ? 4'h0 : hl.idx + 4'h1; // see RQ22
    next_prs = prs;
    next_hl = hl;
    next_connCmd = '0;
    next_nameValid = 1'b0;
    next_nameData = nameData;
    next_monitorEnter = 1'b0;
    next_connCancel = 1'b0;
    next_bootPend = bootPend;
    if (rxValid && manualOn) // see RQ1
    begin
      next_prs.first = 1'b0;
      unique case (prs.st)
        scp_pkg::PS_IDLE:
          if (rxData == scp_pkg::CH_CONNECT) // see RQ2
          begin
            next_prs = '0;
            next_prs.st = scp_pkg::PS_ADDR;
            next_prs.first = 1'b1;
          end
        scp_pkg::PS_ADDR:
          if (isDigit)
          begin
            next_prs.acc = ow[7:0];
            next_prs.dig = 1'b1;
            if (ow > 12'd255)
              next_prs.st = scp_pkg::PS_DROP; // see RQ21
          end
          else if (prs.first && !isTerm && rxData != 8'h20)
          begin
            next_prs.st = scp_pkg::PS_NAME; // see RQ11
            next_nameValid = 1'b1;
            next_nameData = rxData;
          end
          else if (!prs.dig)
            next_prs.st = isTerm ? scp_pkg::PS_IDLE : scp_pkg::PS_DROP; // see RQ21
          else if (rxData == scp_pkg::CH_DOT && prs.nOct < 3'd3) // see RQ5
          begin
            next_prs.addr = fa;
            next_prs.nOct = fn;
            next_prs.acc = 8'h00;
            next_prs.dig = 1'b0;
          end
          else if (rxData == scp_pkg::CH_SLASH) // see RQ7
          begin
            next_prs.addr = fa;
            next_prs.nOct = fn;
            next_prs.dig = 1'b0;
            next_prs.st = scp_pkg::PS_PORT;
          end
          else if (isTerm)
          begin
            next_prs.addr = fa;
            next_prs.nOct = fn;
            next_prs.port = cfg.remPort; // see RQ8
            fin = 1'b1;
          end
          else
            next_prs.st = scp_pkg::PS_DROP; // see RQ21
        scp_pkg::PS_PORT, scp_pkg::PS_NPORT:
          if (isDigit && pw <= 20'd65535)
          begin
            next_prs.port = pw[15:0];
            next_prs.dig = 1'b1;
          end
          else if (isTerm && prs.dig)
          begin
            fin = prs.st == scp_pkg::PS_PORT;
            nameFin = prs.st == scp_pkg::PS_NPORT;
          end
          else
            next_prs.st = isTerm ? scp_pkg::PS_IDLE : scp_pkg::PS_DROP; // see RQ21
        scp_pkg::PS_NAME:
          if (isTerm)
          begin
            next_prs.port = cfg.remPort;
            nameFin = 1'b1;
          end
          else if (rxData == scp_pkg::CH_SLASH || rxData == scp_pkg::CH_COLON) // see RQ12
            next_prs.st = scp_pkg::PS_NPORT;
          else if (rxData == 8'h20)
            next_prs.st = scp_pkg::PS_DROP;
          else
          begin
            next_nameValid = 1'b1;
            next_nameData = rxData;
          end
        scp_pkg::PS_DROP:
          if (isTerm)
            next_prs.st = scp_pkg::PS_IDLE;
        default:
          next_prs.st = scp_pkg::PS_IDLE;
      endcase
    end
    if (fin || nameFin)
      next_prs.st = scp_pkg::PS_IDLE;
    if (fin)
    begin
      unique case (next_prs.nOct) // see RQ9
        3'd1:    fa = {cfg.remAddr[31:8], next_prs.addr[7:0]};
        3'd2:    fa = {cfg.remAddr[31:16], next_prs.addr[15:0]};
        3'd3:    fa = {cfg.remAddr[31:24], next_prs.addr[23:0]};
        default: fa = next_prs.addr;
      endcase
      if (next_prs.nOct == 3'd4 && fa == 32'h0000_0000 && next_prs.port == 16'h0000)
        next_monitorEnter = 1'b1; // see RQ10
      else if (next_prs.port != 16'h0000) // see RQ7
        next_connCmd = '{1'b1, scp_pkg::SRC_MANUAL, 1'b0, fa, next_prs.port}; // see RQ1
    end
    if (nameFin && next_prs.port != 16'h0000)
      next_connCmd = '{1'b1, scp_pkg::SRC_MANUAL, 1'b1, 32'h0000_0000, next_prs.port};
    if (!manualOn)
      next_prs.st = scp_pkg::PS_IDLE; // see RQ1
    if (autoOn && bootPend)
    begin
      next_bootPend = 1'b0;
      next_connCmd = '{1'b1, scp_pkg::SRC_AUTO, 1'b0, cfg.remAddr, cfg.remPort}; // see RQ13
    end
    // host table walk with per-attempt millisecond timer
    next_hl.pre = (int'(hl.pre) >= CYC_PER_MS - 1) ? 16'h0000 : hl.pre + 16'h0001;
    if (int'(hl.pre) >= CYC_PER_MS - 1 && hl.ms != 16'hFFFF)
      next_hl.ms = hl.ms + 16'h0001;
    unique case (hl.st)
      scp_pkg::HL_OFF:
        if (hlCount != 4'h0)
        begin
          next_hl = '0;
          next_hl.st = scp_pkg::HL_ISSUE;
        end
      scp_pkg::HL_ISSUE:
      begin
        next_connCmd = '{1'b1, scp_pkg::SRC_LIST, 1'b0, cfg.hAddr[hl.idx],
                         cfg.hPort[hl.idx]}; // see RQ14
        next_hl.ms = 16'h0000;
        next_hl.pre = 16'h0000;
        next_hl.st = scp_pkg::HL_WAIT;
      end
      scp_pkg::HL_WAIT:
        if (connUp)
          next_hl.st = scp_pkg::HL_UP; // see RQ14
        else if (connFail || hl.ms >= cfg.tmo) // see RQ20
        begin
          next_connCancel = !connFail;
          next_hl.st = scp_pkg::HL_ISSUE;
          next_hl.tries = hl.tries + 4'h1;
          if (hl.tries + 4'h1 >= cfg.retry) // see RQ19
          begin
            next_hl.tries = 4'h0;
            next_hl.idx = nextIdx;
          end
        end
      scp_pkg::HL_UP:
        if (connDown)
        begin
          next_hl.st = scp_pkg::HL_ISSUE; // see RQ15
          next_hl.tries = 4'h0;
          next_hl.idx = nextIdx;
        end
    endcase
    if (!listOn || hlCount == 4'h0)
      next_hl.st = scp_pkg::HL_OFF; // see RQ17
  end

  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      prs          <= '0;
      hl           <= '0;
      connCmd      <= '0;
      nameValid    <= 1'b0;
      nameData     <= 8'h00;
      monitorEnter <= 1'b0;
      connCancel   <= 1'b0;
      bootPend     <= 1'b1;
    end
    else
    begin
      prs          <= next_prs;
      hl           <= next_hl;
      connCmd      <= next_connCmd;
      nameValid    <= next_nameValid;
      nameData     <= next_nameData;
      monitorEnter <= next_monitorEnter;
      connCancel   <= next_connCancel;
      bootPend     <= next_bootPend;
    end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_start_c;
    prs.st == scp_pkg::PS_IDLE && rxValid && rxData != scp_pkg::CH_CONNECT
      |=> prs.st == scp_pkg::PS_IDLE;
  endproperty
  a_start_c: assert property (p_start_c) else $error("parse began without C"); // see RQ2
  property p_manual_term;
    connCmd.valid && connCmd.src == scp_pkg::SRC_MANUAL
      |-> $past(rxValid) && ($past(rxData) == scp_pkg::CH_CR || $past(rxData) == scp_pkg::CH_LF);
  endproperty
  a_manual_term: assert property (p_manual_term) else $error("connect without end"); // see RQ1
  property p_default_port;
    $past(prs.st == scp_pkg::PS_ADDR && !manualOn == 1'b0) && connCmd.valid
      && connCmd.src == scp_pkg::SRC_MANUAL && !connCmd.isName |-> connCmd.port == cfg.remPort
      || $past(prs.st) != scp_pkg::PS_ADDR;
  endproperty
  a_default_port: assert property (p_default_port) else $error("stored port unused"); // see RQ8
  property p_merge;
    $past(prs.st == scp_pkg::PS_ADDR && prs.nOct == 3'd0) && connCmd.valid && !connCmd.isName
      && connCmd.src == scp_pkg::SRC_MANUAL |-> connCmd.addr[31:8] == cfg.remAddr[31:8];
  endproperty
  a_merge: assert property (p_merge) else $error("high bytes not stored"); // see RQ9
  property p_monitor;
    monitorEnter |-> !connCmd.valid;
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor also connected"); // see RQ10
  property p_drop;
    prs.st == scp_pkg::PS_DROP && !(rxValid && isTerm) && manualOn
      |=> prs.st == scp_pkg::PS_DROP && !connCmd.valid;
  endproperty
  a_drop: assert property (p_drop) else $error("bad command left drop"); // see RQ21
  property p_list_off;
    !listOn |=> hl.st == scp_pkg::HL_OFF ##1 !(connCmd.valid && connCmd.src == scp_pkg::SRC_LIST);
  endproperty
  a_list_off: assert property (p_list_off) else $error("table used while off"); // see RQ17
  property p_stay_up;
    hl.st == scp_pkg::HL_UP && !connDown && listOn |=> hl.st == scp_pkg::HL_UP ##1 !connCmd.valid
      || !listOn;
  endproperty
  a_stay_up: assert property (p_stay_up) else $error("tried more while up"); // see RQ14
  property p_wait;
    listOn && hl.st == scp_pkg::HL_WAIT && !connUp && !connFail && hl.ms < cfg.tmo
      |=> hl.st == scp_pkg::HL_WAIT;
  endproperty
  a_wait: assert property (p_wait) else $error("attempt ended early"); // see RQ20
  property p_idx;
    hl.st != scp_pkg::HL_OFF |-> int'(hl.idx) < scp_pkg::HOST_MAX && hl.idx < hlCount;
  endproperty
  a_idx: assert property (p_idx) else $error("table index out of list"); // see RQ22
  property p_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles");
endmodule

`default_nettype wire

// >>> scp_pkg.sv
// constants and carriers for the serial connect command parser
// assumes one 20 MHz clock and a 32-bit classic Wishbone register bus
package scp_pkg;
  // command characters
  localparam logic [7:0] CH_CONNECT = 8'h43;
  localparam logic [7:0] CH_CR      = 8'h0D;
  localparam logic [7:0] CH_LF      = 8'h0A;
  localparam logic [7:0] CH_SLASH   = 8'h2F;
  localparam logic [7:0] CH_COLON   = 8'h3A;
  localparam logic [7:0] CH_DOT     = 8'h2E;
  localparam logic [7:0] CH_ZERO    = 8'h30;
  localparam logic [7:0] CH_NINE    = 8'h39;
  // policy field codes
  localparam logic [3:0] POL_MANUAL = 4'h4;
  localparam logic [3:0] POL_AUTO   = 4'h5;
  localparam logic [3:0] POL_LIST   = 4'h2;
  // register byte offsets
  localparam logic [7:0] REG_POLICY   = 8'h00;
  localparam logic [7:0] REG_REM_ADDR = 8'h04;
  localparam logic [7:0] REG_REM_PORT = 8'h08;
  localparam logic [7:0] REG_RETRY    = 8'h0C;
  localparam logic [7:0] REG_TMO      = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;
  localparam logic [7:0] REG_HOST     = 8'h40;
  localparam int         HOST_MAX     = 12;
  // limits and reset values
  localparam logic [7:0]  POLICY_RST = 8'hC0;
  localparam logic [3:0]  RETRY_RST  = 4'h3;
  localparam logic [3:0]  RETRY_MIN  = 4'h1;
  localparam logic [15:0] TMO_RST    = 16'h00FA;
  localparam logic [15:0] TMO_MIN    = 16'h000A;
  // timeout unit
  localparam int MS_NS      = 1000000;
  localparam int CLK_NS     = 50;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  // request sources
  localparam logic [1:0] SRC_MANUAL = 2'h1;
  localparam logic [1:0] SRC_AUTO   = 2'h2;
  localparam logic [1:0] SRC_LIST   = 2'h3;

  typedef enum logic [2:0] {PS_IDLE = 3'b000, PS_ADDR = 3'b001, PS_PORT = 3'b010,
                            PS_NAME = 3'b011, PS_NPORT = 3'b100, PS_DROP = 3'b101} scp_prs_e;
  typedef enum logic [1:0] {HL_OFF = 2'b00, HL_ISSUE = 2'b01, HL_WAIT = 2'b10,
                            HL_UP = 2'b11} scp_hl_e;

  typedef struct packed {
    scp_prs_e    st;
    logic        first;
    logic [31:0] addr;
    logic [2:0]  nOct;
    logic [7:0]  acc;
    logic        dig;
    logic [15:0] port;
  } scp_prs_s;
  typedef struct packed {
    scp_hl_e     st;
    logic [3:0]  idx;
    logic [3:0]  tries;
    logic [15:0] ms;
    logic [15:0] pre;
  } scp_hl_s;
  typedef struct packed {
    logic        valid;
    logic [1:0]  src;
    logic        isName;
    logic [31:0] addr;
    logic [15:0] port;
  } scp_req_s;
  typedef struct packed {
    logic [7:0]                    policy;
    logic [31:0]                   remAddr;
    logic [15:0]                   remPort;
    logic [3:0]                    retry;
    logic [15:0]                   tmo;
    logic [HOST_MAX-1:0][31:0]     hAddr;
    logic [HOST_MAX-1:0][15:0]     hPort;
  } scp_cfg_s;

  localparam scp_cfg_s CFG_RST = '{policy: POLICY_RST, retry: RETRY_RST, tmo: TMO_RST,
                                   default: '0};
endpackage

// >>> tb_serial_connect_command_parser.sv
// self-checking bench for the connect command parser
// assumes scp_pkg, scp_parser and scp_host_model compiled before it
`timescale 1ns/100ps
`default_nettype none
module tb_serial_connect_command_parser;
  logic              core_clk, sys_rst, cyc, stb, we, ack, connUp, connFail, connDown;
  logic              rxValid, nameValid, connCancel, monitorEnter, refuseIncoming;
  logic [7:0]        adr, rxData, nameData;
  logic [3:0]        sel;
  logic [31:0]       wdat, wbDat, rdat, rnd, st, nameSeen;
  scp_pkg::scp_req_s connCmd;
  scp_pkg::scp_req_s cmdQ[$];
  int                miscompares, samplesChecked, nameCnt, monCnt, cancelCnt, m0;
  string             bads[6] = '{"C1 2\015", "C256\015", "C1/0\015", "C1/65536\015",
                                 "C1.2.3.4.5\015", "x5\015"};

  scp_parser #(.CYC_PER_MS(10)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wbDat), .wb_ack_o(ack), .rxValid(rxValid), .rxData(rxData),
    .connCmd(connCmd), .nameValid(nameValid), .nameData(nameData), .connCancel(connCancel),
    .monitorEnter(monitorEnter), .refuseIncoming(refuseIncoming), .connUp(connUp),
    .connFail(connFail), .connDown(connDown));
  scp_host_model host (.core_clk(core_clk), .rxValid(rxValid), .rxData(rxData));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // collect engine requests and count pulses
  always @(posedge core_clk)
  begin
    if (connCmd.valid === 1'b1)
      cmdQ.push_back(connCmd);
    nameCnt   += (nameValid === 1'b1);
    monCnt    += (monitorEnter === 1'b1);
    cancelCnt += (connCancel === 1'b1);
    if (nameValid === 1'b1)
      nameSeen = {nameSeen[23:0], nameData};
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // low n bytes from the command, the rest from the stored address
  function automatic logic [31:0] part(input logic [31:0] g, input int n);
    logic [31:0] m;
    m = (n == 4) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (8 * n)) - 1);
    return (st & ~m) | (g & m);
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
      @(posedge core_clk);
    while (ack !== 1'b1);
    rdat = wbDat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, rdat, exp);
  endtask

  task automatic expCmd(input logic [1:0] s, input logic [31:0] a, input logic [15:0] p,
                        input logic isN);
    scp_pkg::scp_req_s c;
    int n;
    n = 0;
    while (cmdQ.size() == 0 && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    c = (cmdQ.size() != 0) ? cmdQ.pop_front() : '0;
    chk("request", {c.src, c.isName, c.addr, c.port}, {s, isN, a, p});
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge core_clk);
    chk("no request", cmdQ.size(), 0);
    cmdQ.delete();
  endtask

  task automatic mc(input string s, input logic [31:0] a, input logic [15:0] p, input int g);
    host.sendStr(s, g);
    expCmd(scp_pkg::SRC_MANUAL, a, p, 1'b0);
  endtask

  task automatic ev(input logic [2:0] e);
    {connUp, connFail, connDown} <= e;
    @(posedge core_clk);
    {connUp, connFail, connDown} <= 3'b000;
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #(50 * 20000);
    miscompares++;
    testDone();
  end

  initial
  begin
    {sys_rst, cyc, stb, we, connUp, connFail, connDown} = 7'b100_0000;
    adr  = 8'h00;
    wdat = 32'h0000_0000;
    sel  = 4'hF;
    rnd  = 32'hbbc4_4aa8;
    st   = 32'h8101_0203;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd("policy", scp_pkg::REG_POLICY, 32'h0000_00C0);
    rd("retry", scp_pkg::REG_RETRY, 32'h0000_0003);
    rd("timeout", scp_pkg::REG_TMO, 32'h0000_00FA);
    rd("unmapped", 8'hA0, 32'h0000_0000);
    wb(1'b1, scp_pkg::REG_RETRY, 32'h0000_0000);
    rd("retry floor", scp_pkg::REG_RETRY, 32'h0000_0001);
    wb(1'b1, scp_pkg::REG_TMO, 32'h0000_0005);
    rd("timeout floor", scp_pkg::REG_TMO, 32'h0000_000A);
    wb(1'b1, scp_pkg::REG_RETRY, 32'h0000_0002);
    wb(1'b1, scp_pkg::REG_REM_ADDR, st);
    wb(1'b1, scp_pkg::REG_REM_PORT, 32'h0000_04D2);
    wb(1'b1, scp_pkg::REG_POLICY, 32'h0000_00C5);
    expCmd(scp_pkg::SRC_AUTO, st, 16'h04D2, 1'b0);
    quiet(100);
    $display("test autostart done");
    wb(1'b1, scp_pkg::REG_POLICY, 32'h0000_00C4);
    quiet(50);
    chk("refuse", refuseIncoming, 0);
    mc("C121.2.4.5/1\015", 32'h7902_0405, 16'h0001, 0);
    mc("C5\015", part(32'h0000_0005, 1), 16'h04D2, 0);
    mc("C28.10/12\n", part(32'h0000_1C0A, 2), 16'h000C, 0);
    mc("C1.2.3/65535\015", part(32'h0001_0203, 3), 16'hFFFF, 2);
    for (int i = 0; i < 8; i++)
    begin
      rnd = xs(rnd);
      mc($sformatf("C%0d.%0d/%0d\015", rnd[7:0], rnd[15:8], rnd[31:16] | 16'h0001),
         part({16'h0000, rnd[7:0], rnd[15:8]}, 2), rnd[31:16] | 16'h0001, i % 2);
    end
    m0 = monCnt;
    host.sendStr("C0.0.0.0/0\015", 0);
    quiet(5);
    chk("monitor", monCnt - m0, 1);
    foreach (bads[i])
    begin
      host.sendStr(bads[i], 0);
      quiet(20);
    end
    mc("C7\015", part(32'h0000_0007, 1), 16'h04D2, 0);
    m0 = nameCnt;
    host.sendStr("Cab.cd:80\015", 0);
    expCmd(scp_pkg::SRC_MANUAL, 0, 16'h0050, 1'b1);
    chk("name chars", nameCnt - m0, 5);
    chk("name data", nameSeen, 32'h622E_6364);
    host.sendStr("Cxy/443\n", 1);
    expCmd(scp_pkg::SRC_MANUAL, 0, 16'h01BB, 1'b1);
    chk("name data", nameSeen[15:0], 16'h7879);
    $display("test manual done");
    wb(1'b1, 8'h40, 32'hAC13_0001);
    wb(1'b1, 8'h44, 32'h0000_0017);
    wb(1'b1, 8'h48, 32'hAC13_0002);
    wb(1'b1, 8'h4C, 32'h0000_0BB9);
    wb(1'b1, scp_pkg::REG_POLICY, 32'h0000_0020);
    chk("refuse", refuseIncoming, 1);
    expCmd(scp_pkg::SRC_LIST, 32'hAC13_0001, 16'h0017, 1'b0);
    ev(3'b010);
    expCmd(scp_pkg::SRC_LIST, 32'hAC13_0001, 16'h0017, 1'b0);
    ev(3'b010);
    expCmd(scp_pkg::SRC_LIST, 32'hAC13_0002, 16'h0BB9, 1'b0);
    ev(3'b010);
    expCmd(scp_pkg::SRC_LIST, 32'hAC13_0002, 16'h0BB9, 1'b0);
    ev(3'b010);
    expCmd(scp_pkg::SRC_LIST, 32'hAC13_0001, 16'h0017, 1'b0);
    ev(3'b100);
    quiet(300);
    ev(3'b001);
    expCmd(scp_pkg::SRC_LIST, 32'hAC13_0002, 16'h0BB9, 1'b0);
    m0 = cancelCnt;
    expCmd(scp_pkg::SRC_LIST, 32'hAC13_0002, 16'h0BB9, 1'b0);
    chk("cancel", cancelCnt - m0, 1);
    wb(1'b1, scp_pkg::REG_POLICY, 32'h0000_00C4);
    chk("refuse", refuseIncoming, 0);
    quiet(300);
    wb(1'b1, scp_pkg::REG_POLICY, 32'h0000_0024);
    chk("refuse", refuseIncoming, 0);
    quiet(300);
    wb(1'b1, scp_pkg::REG_POLICY, 32'h0000_00C6);
    host.sendStr("C5\015", 0);
    quiet(20);
    $display("test host table done");
    testDone();
  end
endmodule
`default_nettype wire
